// ---- verilog/tfg_pkg.sv ----
// Purpose: constants, types and helpers for the test frame generator.
// Assumes: 100 MHz sys_clk, APB register access, byte-wide frame stream.
// Notes: byte address of a register is four times its index.
package tfg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_IDX = 8'h1D; // control register index
  localparam logic [7:0] WORD_IDX = 8'h1E; // payload word index
  localparam logic [7:0] STAT_IDX = 8'h1F; // status register index
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_IDX * 4);
  localparam logic [7:0] WORD_ADDR = 8'(WORD_IDX * 4);
  localparam logic [7:0] STAT_ADDR = 8'(STAT_IDX * 4);
  localparam logic [15:0] CTRL_RESET = 16'h0040; // destination nibble 0001
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // control field positions
  localparam int EN_BIT = 15;
  localparam int RUN_BIT = 14;
  localparam int CONT_BIT = 13;
  localparam int LEN_LSB = 11;
  localparam int GAP_BIT = 10;
  localparam int DA_LSB = 6;
  localparam int SA_LSB = 2;
  localparam int RAND_BIT = 1;
  localparam int BAD_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;

  // ****************************************************************
  // frame and timing figures
  // ****************************************************************
  localparam logic [15:0] LEN_125 = 16'd125;
  localparam logic [15:0] LEN_64 = 16'd64;
  localparam logic [15:0] LEN_1518 = 16'd1518;
  localparam int LEN_JUMBO = 10000;
  localparam int BURST_FRAMES = 30000000;
  localparam int STEP_FRAMES = 10000;
  localparam logic [15:0] HDR_END = 16'd13; // last header byte index
  localparam logic [15:0] ETH_TYPE = 16'h88B5; // local experimental type
  localparam int CLK_PERIOD_NS = 10;
  localparam int GAP_SHORT_NS = 96;
  localparam int GAP_LONG_NS = 8192;
  // least times, so round up to whole cycles
  localparam logic [9:0] GAP_SHORT_CYC = 10'((GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] GAP_LONG_CYC = 10'((GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] CRC_POLY = 32'hEDB88320; // reflected CRC-32
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // generator states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_FCS = 2'b10,
    ST_GAP = 2'b11
  } tfg_state_e;

  // one byte of the outgoing stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tfg_beat_s;

  // crc update over one byte, least significant bit first
  function automatic logic [31:0] tfg_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ---- verilog/tfg_top.sv ----
// Purpose: test frame generator with APB registers and output FIFO.
// Assumes: tx_ready drains the stream; all inputs synchronous to sys_clk.
// Notes: frames carry no preamble; check sequence sent low byte first.
`timescale 1ns/10ps

// ****************************************************************
// output FIFO
// ****************************************************************
module tfg_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam logic [PW:0] DEPTH = (PW+1)'(D);

  generate
    if (D < 2) begin : g_bad_depth
      $error("tfg_fifo depth must be at least 2");
    end
  endgenerate

  logic [W-1:0] mem [D]; // storage, no reset needed
  logic [PW-1:0] wp_reg, wp_next; // write pointer
  logic [PW-1:0] rp_reg, rp_next; // read pointer
  logic [PW:0] cnt_reg, cnt_next; // words held
  logic ov_reg, ov_next; // output stage valid
  logic [W-1:0] od_reg, od_next; // output stage data
  logic wr, ld;

  assign in_ready = (cnt_reg < DEPTH);
  assign out_valid = ov_reg;
  assign out_data = od_reg;

  // pointer and output stage next values
  always_comb begin
    wr = in_valid && in_ready;
    // output stage refills whenever it is empty or being taken
    ld = (cnt_reg != '0) && (!ov_reg || out_ready);
    wp_next = wr ? ((wp_reg == PW'(D - 1)) ? '0 : PW'(wp_reg + 1'b1)) : wp_reg;
    rp_next = ld ? ((rp_reg == PW'(D - 1)) ? '0 : PW'(rp_reg + 1'b1)) : rp_reg;
    cnt_next = cnt_reg;
    if (wr && !ld) begin
      cnt_next = (PW+1)'(cnt_reg + 1'b1);
    end else if (ld && !wr) begin
      cnt_next = (PW+1)'(cnt_reg - 1'b1);
    end
    ov_next = ov_reg;
    od_next = od_reg;
    if (ld) begin
      ov_next = 1'b1;
      od_next = mem[rp_reg];
    end else if (out_ready) begin
      ov_next = 1'b0;
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ov_reg <= 1'b0;
      od_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      ov_reg <= ov_next;
      od_reg <= od_next;
    end
  end

  // storage write
  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem[wp_reg] <= in_data;
    end
  end

  // occupancy never passes the depth
  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cnt_reg <= DEPTH) else $error("fifo count above depth");

endmodule

// ****************************************************************
// generator top
// ****************************************************************
module tfg_top #(
  parameter int BURST_FRAMES = tfg_pkg::BURST_FRAMES,
  parameter int STEP_FRAMES = tfg_pkg::STEP_FRAMES,
  parameter int JUMBO_BYTES = tfg_pkg::LEN_JUMBO,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tfg_pkg::tfg_beat_s tx_beat,
  output logic tx_valid,
  input wire logic tx_ready
);
  import tfg_pkg::*;

  generate
    if (BURST_FRAMES < 1 || STEP_FRAMES < 1 || JUMBO_BYTES < 64 || JUMBO_BYTES > 65535)
    begin : g_bad_param
      $error("tfg_top parameter out of range");
    end
  endgenerate

  // ****************************************************************
  // register file over APB
  // ****************************************************************
  logic [15:0] ctrl_reg, ctrl_next; // live control bits
  logic [15:0] word_reg, word_next; // live payload word
  logic pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic busy; // generator not idle
  logic hit; // address decodes to a register

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // one wait cycle, then answer; write lands at the pready edge
  always_comb begin
    ctrl_next = ctrl_reg;
    word_next = word_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = 1'b0;
    hit = (paddr == CTRL_ADDR) || (paddr == WORD_ADDR) || (paddr == STAT_ADDR);
    if (psel && penable && !pready_reg) begin
      // access phase first cycle: prepare the answer
      pready_next = 1'b1;
      pslverr_next = !hit;
      case (paddr)
        CTRL_ADDR: prdata_next = {16'h0000, ctrl_reg};
        WORD_ADDR: prdata_next = {16'h0000, word_reg};
        STAT_ADDR: prdata_next = 32'(busy) << STAT_BUSY_BIT;
        default: prdata_next = 32'h00000000;
      endcase
    end else if (psel && penable && pready_reg && pwrite) begin
      // status is read only; unmapped writes are dropped
      if (paddr == CTRL_ADDR) begin
        ctrl_next = pwdata[15:0];
      end else if (paddr == WORD_ADDR) begin
        word_next = pwdata[15:0];
      end
    end
  end

  // register file flops
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
      word_reg <= WORD_RESET;
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      word_reg <= word_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ****************************************************************
  // frame generator
  // ****************************************************************
  tfg_state_e st_reg, st_next;
  logic [13:0] cfg_reg, cfg_next; // control snapshot taken at start
  logic [15:0] wsn_reg, wsn_next; // payload word snapshot
  logic [15:0] idx_reg, idx_next; // byte index within frame
  logic [9:0] gap_reg, gap_next; // idle cycles left
  logic [31:0] crc_reg, crc_next;
  logic [15:0] lfsr_reg, lfsr_next;
  logic [31:0] frames_reg, frames_next; // frames since start
  logic [31:0] step_reg, step_next; // position inside 10,000 step
  logic go_prev_reg, go_prev_next;
  logic req_reg, req_next; // pending restart request
  logic go, push, frame_end, stop;
  logic [15:0] flen;
  logic [31:0] fcs;
  tfg_beat_s beat;
  logic fifo_ready;

  assign go = ctrl_reg[EN_BIT] && ctrl_reg[RUN_BIT];
  assign busy = (st_reg != ST_IDLE);

  // frame length from the snapshot length field
  always_comb begin
    case (cfg_reg[LEN_LSB +: 2])
      2'b00: flen = LEN_125;
      2'b01: flen = LEN_64;
      2'b10: flen = LEN_1518;
      default: flen = 16'(JUMBO_BYTES);
    endcase
  end

  // good check is the complemented crc, bad one is not
  // bad check selected for the whole run by snapshot bit
  assign fcs = cfg_reg[BAD_BIT] ? crc_reg : ~crc_reg;

  // byte selection and sequencing
  always_comb begin
    st_next = st_reg;
    cfg_next = cfg_reg;
    wsn_next = wsn_reg;
    idx_next = idx_reg;
    gap_next = gap_reg;
    crc_next = crc_reg;
    lfsr_next = lfsr_reg;
    frames_next = frames_reg;
    step_next = step_reg;
    go_prev_next = go;
    push = 1'b0;
    frame_end = 1'b0;
    stop = 1'b0;
    beat.data = 8'h00;
    beat.last = 1'b0;
    // a fresh run edge asks for a restart with new settings
    req_next = (go && !go_prev_reg) ? 1'b1 : (go ? req_reg : 1'b0);
    case (st_reg)
      ST_IDLE: begin
        // start on run edge, snapshot settings
        if (go && req_reg) begin
          // control bits 13:0 captured here only
          cfg_next = ctrl_reg[13:0];
          wsn_next = word_reg;
          req_next = 1'b0;
          idx_next = 16'h0000;
          crc_next = CRC_INIT;
          frames_next = 32'h00000000;
          step_next = 32'h00000000;
          st_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (idx_reg <= 16'd5) begin
          // destination all ones, nibble from snapshot
          beat.data = (idx_reg == 16'd5) ? {4'hF, cfg_reg[DA_LSB +: 4]} : 8'hFF;
        end else if (idx_reg <= 16'd11) begin
          // source all ones, nibble from snapshot
          beat.data = (idx_reg == 16'd11) ? {4'hF, cfg_reg[SA_LSB +: 4]} : 8'hFF;
        end else if (idx_reg <= HDR_END) begin
          beat.data = idx_reg[0] ? ETH_TYPE[7:0] : ETH_TYPE[15:8];
        end else if (cfg_reg[RAND_BIT]) begin
          beat.data = lfsr_reg[7:0];
        end else begin
          // fixed word repeated, high byte first
          beat.data = idx_reg[0] ? wsn_reg[7:0] : wsn_reg[15:8];
        end
        // fifo back-pressure stalls the frame byte by byte
        if (fifo_ready) begin
          push = 1'b1;
          crc_next = tfg_crc_byte(crc_reg, beat.data);
          if (idx_reg > HDR_END) begin
            lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
          end
          idx_next = 16'(idx_reg + 16'd1);
          if (idx_reg == 16'(flen - 16'd5)) begin
            st_next = ST_FCS;
          end
        end
      end
      ST_FCS: begin
        // count from the first check byte: frame lengths need not be multiples of four
        beat.data = fcs[8 * 2'(idx_reg - flen) +: 8];
        beat.last = (idx_reg == 16'(flen - 16'd1));
        if (fifo_ready) begin
          push = 1'b1;
          // crc register is not updated here; fcs bytes come from it
          idx_next = 16'(idx_reg + 16'd1);
          if (beat.last) begin
            frame_end = 1'b1;
            frames_next = 32'(frames_reg + 32'd1);
            step_next = (step_reg == 32'(STEP_FRAMES - 1)) ? 32'h00000000
                                                           : 32'(step_reg + 32'd1);
            // burst mode ends after the fixed frame count
            if (!cfg_reg[CONT_BIT] && frames_next == 32'(BURST_FRAMES)) begin
              stop = 1'b1;
            end
            // continuous dropped: end at the next step mark
            if (cfg_reg[CONT_BIT] && !ctrl_reg[CONT_BIT] && step_next == 32'h00000000) begin
              stop = 1'b1;
            end
            // run cleared or restart asked: leave after this frame
            if (!go || req_reg) begin
              stop = 1'b1;
            end
            idx_next = 16'h0000;
            // gap length from snapshot gap bit
            gap_next = cfg_reg[GAP_BIT] ? GAP_LONG_CYC : GAP_SHORT_CYC;
            st_next = stop ? ST_IDLE : ST_GAP;
          end
        end
      end
      ST_GAP: begin
        gap_next = 10'(gap_reg - 10'd1);
        if (!go || req_reg) begin
          st_next = ST_IDLE;
        end else if (gap_reg == 10'd1) begin
          crc_next = CRC_INIT;
          st_next = ST_DATA;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // generator flops
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      cfg_reg <= 14'h0000;
      wsn_reg <= 16'h0000;
      idx_reg <= 16'h0000;
      gap_reg <= 10'h000;
      crc_reg <= CRC_INIT;
      lfsr_reg <= LFSR_SEED;
      frames_reg <= 32'h00000000;
      step_reg <= 32'h00000000;
      go_prev_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      wsn_reg <= wsn_next;
      idx_reg <= idx_next;
      gap_reg <= gap_next;
      crc_reg <= crc_next;
      lfsr_reg <= lfsr_next;
      frames_reg <= frames_next;
      step_reg <= step_next;
      go_prev_reg <= go_prev_next;
      req_reg <= req_next;
    end
  end

  // ****************************************************************
  // output buffer
  // ****************************************************************
  tfg_fifo #(
    .W($bits(tfg_beat_s)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(push),
    .in_data(beat),
    .in_ready(fifo_ready),
    .out_valid(tx_valid),
    .out_data(tx_beat),
    .out_ready(tx_ready)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  idle_when_off_a: assert property (
    (st_reg == ST_IDLE && !ctrl_reg[EN_BIT]) |=> st_reg == ST_IDLE)
    else $error("generator left idle while disabled");

  start_on_run_a: assert property (
    (st_reg == ST_IDLE && go && req_reg) |=> (st_reg == ST_DATA && idx_reg == 16'h0000))
    else $error("run edge did not start a frame");

  burst_stop_a: assert property (
    (frame_end && !cfg_reg[CONT_BIT] && frames_next == 32'(BURST_FRAMES))
    |=> st_reg == ST_IDLE && frames_reg == 32'(BURST_FRAMES))
    else $error("burst did not stop at its count");

  step_stop_a: assert property (
    (frame_end && cfg_reg[CONT_BIT] && !ctrl_reg[CONT_BIT] && step_next == 32'h00000000)
    |=> st_reg == ST_IDLE)
    else $error("continuous stop missed the step mark");

  frame_len_a: assert property (
    (push && beat.last) |-> (st_reg == ST_FCS && idx_reg == 16'(flen - 16'd1)))
    else $error("frame length wrong");

  gap_len_a: assert property (
    (st_reg == ST_GAP && $past(st_reg) == ST_FCS)
    |-> gap_reg == (cfg_reg[GAP_BIT] ? GAP_LONG_CYC : GAP_SHORT_CYC))
    else $error("gap length wrong");

  dest_nibble_a: assert property (
    (push && st_reg == ST_DATA && idx_reg == 16'd5)
    |-> beat.data == {4'hF, cfg_reg[DA_LSB +: 4]})
    else $error("destination low byte wrong");

  src_nibble_a: assert property (
    (push && st_reg == ST_DATA && idx_reg == 16'd11)
    |-> beat.data == {4'hF, cfg_reg[SA_LSB +: 4]})
    else $error("source low byte wrong");

  fixed_payload_a: assert property (
    (push && st_reg == ST_DATA && idx_reg > HDR_END && !cfg_reg[RAND_BIT])
    |-> beat.data == (idx_reg[0] ? wsn_reg[7:0] : wsn_reg[15:8]))
    else $error("fixed payload byte wrong");

  cfg_hold_a: assert property (
    (st_reg != ST_IDLE) |=> (st_reg == ST_IDLE || ($stable(cfg_reg) && $stable(wsn_reg))))
    else $error("settings changed during a run");

endmodule

// ---- dv/tfg_sink.sv ----
// Purpose: link partner model that takes generated frames byte by byte.
// Assumes: one byte per accepted beat; last marks the final check byte.
// Notes: slow mode takes one beat in four so the output FIFO backs up.
`timescale 1ns/10ps
module tfg_sink (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire tfg_pkg::tfg_beat_s tx_beat,
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready
);
  import tfg_pkg::*;
  logic [1:0] phase_reg; // slow accept phase
  logic [7:0] cur[$]; // frame being gathered
  logic [7:0] fr[$]; // last whole frame
  int nfr; // frames received so far
  int idle; // cycles since last accepted byte
  int gap; // idle cycles ahead of the latest frame
  // ******************************
  // accept and gather
  // ******************************
  // gap is only meaningful when the sink never stalls
  always @(posedge sys_clk) begin
    if (!rstn) begin
      phase_reg <= 2'h0;
      tx_ready <= 1'b0;
      nfr <= 0;
      idle <= 0;
      gap <= 0;
      cur = {};
    end else begin
      phase_reg <= phase_reg + 2'h1;
      // a busy receiver drops ready; the design must hold its byte
      tx_ready <= !slow || phase_reg == 2'h3;
      idle <= idle + 1;
      if (tx_valid && tx_ready) begin
        if (cur.size() == 0)
          gap <= idle;
        cur.push_back(tx_beat.data);
        idle <= 0;
        if (tx_beat.last) begin
          fr = cur;
          cur = {};
          nfr <= nfr + 1;
        end
      end
    end
  end
endmodule

// ---- dv/tfg_top_test.sv ----
// Purpose: self-checking bench for the test frame generator.
// Assumes: one clock; APB master waits on pready without a fixed count.
// Notes: burst, step and jumbo counts are shrunk to keep runs short.
`timescale 1ns/10ps
module tfg_top_test;
  import tfg_pkg::*;
  localparam int BURST = 3; // shortened burst count
  localparam int STEP = 4; // shortened continuous step
  localparam int JUMBO = 100; // shortened jumbo length
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tfg_beat_s tx_beat;
  logic tx_valid;
  logic tx_ready;
  logic slow = 1'b0; // sink back-pressure mode
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] rd; // last read data
  logic rerr; // last error flag
  int base; // frame count at run start

  tfg_top #(.BURST_FRAMES(BURST), .STEP_FRAMES(STEP), .JUMBO_BYTES(JUMBO),
    .FIFO_DEPTH(16)) dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_beat(tx_beat),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  tfg_sink sink (.sys_clk(sys_clk), .rstn(rstn), .tx_beat(tx_beat),
    .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ******************************
  // helpers
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] cw(input logic [2:0] m, input logic [1:0] len,
      input logic gap, input logic [3:0] da, input logic [3:0] sa, input logic [1:0] lo);
    return {m, len, gap, da, sa, lo};
  endfunction

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (sink.nfr < base + n && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    // frames that never arrive count as a mismatch
    if (sink.nfr < base + n) err_total++;
  endtask

  // short gaps only: a quiet window longer than one frame plus gap
  task automatic wait_quiet();
    int prev;
    do begin
      prev = sink.nfr;
      repeat (300) @(posedge sys_clk);
    end while (sink.nfr != prev);
  endtask

  // reflected crc, least significant bit first
  function automatic logic [31:0] crc(input int n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ sink.fr[i][b]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
    end
    return c;
  endfunction

  task automatic chk_frame(input int len, input logic [3:0] da, input logic [3:0] sa,
      input logic [15:0] w, input logic rnd, input logic bad);
    int diff;
    logic [31:0] c;
    diff = 0;
    chk(sink.fr.size(), len); // frame size
    for (int i = 0; i < 5; i++) begin
      chk(sink.fr[i], 8'hFF); // destination upper bytes
      chk(sink.fr[6 + i], 8'hFF); // source upper bytes
    end
    chk(sink.fr[5], {4'hF, da}); // destination nibble
    chk(sink.fr[11], {4'hF, sa}); // source nibble
    for (int i = 14; i < len - 4; i++) begin
      if (sink.fr[i] !== (i % 2 ? w[7:0] : w[15:8]))
        diff++;
    end
    chk(diff != 0, rnd); // payload kind
    c = crc(len - 4);
    chk({sink.fr[len - 1], sink.fr[len - 2], sink.fr[len - 3], sink.fr[len - 4]},
      bad ? c : ~c); // check sequence
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    apb(1'b0, CTRL_ADDR, 16'h0000);
    chk(rd, 32'h00000040); // control reset
    apb(1'b0, WORD_ADDR, 16'h0000);
    chk(rd, 32'h0); // word reset
    apb(1'b1, 8'h10, 16'hFFFF);
    chk(rerr, 1'b1); // unmapped write refused
    apb(1'b1, WORD_ADDR, 16'hA55A);
    apb(1'b0, WORD_ADDR, 16'h0000);
    chk(rd, 32'h0000A55A); // word read back
  endtask

  task automatic t_noenable();
    base = sink.nfr;
    apb(1'b1, CTRL_ADDR, cw(3'b010, 2'b01, 1'b0, 4'h1, 4'h0, 2'b00));
    repeat (300) @(posedge sys_clk);
    chk(sink.nfr, base); // silent without enable
    apb(1'b1, CTRL_ADDR, 16'h0040);
  endtask

  // every length code, both gaps, both payloads, both check kinds
  task automatic t_lengths();
    int lens[4];
    int gmin;
    int gmax;
    lens = '{125, 64, 1518, JUMBO};
    for (int i = 0; i < 4; i++) begin
      slow <= (i == 0);
      apb(1'b1, WORD_ADDR, 16'h1234 + 16'(i));
      apb(1'b1, CTRL_ADDR, cw(3'b100, 2'b00, 1'b0, 4'h0, 4'h0, 2'b00));
      base = sink.nfr;
      apb(1'b1, CTRL_ADDR, cw(3'b110, 2'(i), i == 1, 4'(i + 2), 4'(9 - i), {i == 2, i[0]}));
      wait_frames(BURST);
      repeat (1200) @(posedge sys_clk);
      chk(sink.nfr - base, BURST); // burst stops by itself
      chk_frame(lens[i], 4'(i + 2), 4'(9 - i), 16'h1234 + 16'(i), i == 2, i[0]);
      gmin = (i == 1) ? GAP_LONG_CYC : GAP_SHORT_CYC;
      gmax = (i == 1) ? 3000 : GAP_LONG_CYC;
      if (i > 0)
        chk(sink.gap >= gmin && sink.gap < gmax, 1'b1); // idle gap
    end
    slow <= 1'b0;
    apb(1'b1, CTRL_ADDR, 16'h0040);
  endtask

  task automatic t_cont();
    apb(1'b1, WORD_ADDR, 16'h1234);
    base = sink.nfr;
    apb(1'b1, CTRL_ADDR, cw(3'b111, 2'b01, 1'b0, 4'h1, 4'h2, 2'b00));
    wait_frames(5);
    apb(1'b0, STAT_ADDR, 16'h0000);
    chk(rd, 32'h00000001); // busy while running
    // edits while running must wait for a restart
    apb(1'b1, WORD_ADDR, 16'hBEEF);
    apb(1'b1, CTRL_ADDR, cw(3'b110, 2'b01, 1'b0, 4'h1, 4'h7, 2'b00));
    wait_quiet();
    apb(1'b0, STAT_ADDR, 16'h0000);
    chk(rd, 32'h00000000); // idle after the step mark
    chk((sink.nfr - base) % STEP, 0); // stop on step mark
    chk(sink.nfr - base >= 2 * STEP, 1'b1); // ran on to the mark
    chk_frame(64, 4'h1, 4'h2, 16'h1234, 1'b0, 1'b0); // old settings kept
    apb(1'b1, CTRL_ADDR, cw(3'b100, 2'b01, 1'b0, 4'h1, 4'h7, 2'b00));
    base = sink.nfr;
    apb(1'b1, CTRL_ADDR, cw(3'b110, 2'b01, 1'b0, 4'h1, 4'h7, 2'b00));
    wait_frames(BURST);
    chk_frame(64, 4'h1, 4'h7, 16'hBEEF, 1'b0, 1'b0); // new settings
    apb(1'b1, CTRL_ADDR, 16'h0040);
  endtask

  // ******************************
  // run control
  // ******************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_noenable();
    t_lengths();
    t_cont();
    end_of_test();
  end

  // scenarios need about 15,000 cycles; this leaves ample margin
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule
